// file: mdd_regs.svh
`ifndef MDD_REGS_SVH
`define MDD_REGS_SVH
`define MDD_SFR_SP        8'h81
`define MDD_SFR_PSW       8'hd0
`define MDD_SFR_PROGRAM_STORE_CONTROL     8'h8f
`define MDD_SP_RESET      8'h07
`define MDD_PSW_RESET     8'h00
`define MDD_PROGRAM_STORE_CONTROL_RESET   8'h00
`define MDD_PROGRAM_STORE_CONTROL_WE_BIT  0
`define MDD_PSW_RS0_BIT   3
`define MDD_PSW_RS1_BIT   4
`define MDD_DIRECT_TOP    8'h7f
`define MDD_BITAREA_BASE  8'h20
`define MDD_FLASH_8K_TOP  16'h1fff
`define MDD_FLASH_8K_RSV  16'h1dff
`define MDD_FLASH_4K_TOP  16'h0fff
`define MDD_FLASH_2K_TOP  16'h07ff
`endif

// file: mdd_pkg.sv
package mdd_pkg;
  typedef enum logic [2:0] {
    MDD_OP_NONE   = 3'b000,
    MDD_OP_DIRECT = 3'b001,
    MDD_OP_INDIR  = 3'b010,
    MDD_OP_BIT    = 3'b011,
    MDD_OP_CODE   = 3'b100,
    MDD_OP_PUSH   = 3'b101,
    MDD_OP_POP    = 3'b110
  } mdd_op_t;

  typedef enum logic [1:0] {
    MDD_SZ_8K = 2'b00,
    MDD_SZ_4K = 2'b01,
    MDD_SZ_2K = 2'b10
  } mdd_size_t;

  typedef struct packed {
    mdd_op_t     op;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        ptr_sel;
    logic [2:0]  bitpos;
  } mdd_req_t;

  typedef struct packed {
    logic [7:0]  rdata;
    logic        rbit;
    logic        ram_hit;
    logic        sfr_hit;
    logic        code_hit;
    logic        code_rsv;
    logic        code_we;
    logic        err;
    logic [7:0]  eff_addr;
    logic [15:0] code_addr;
  } mdd_rsp_t;

  typedef struct packed {
    logic [7:0] sp;
    logic [7:0] processor_status_word;
    logic [7:0] program_store_control;
    mdd_rsp_t   rsp;
  } mdd_state_t;
endpackage : mdd_pkg

// file: mdd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "mdd_regs.svh"
module mdd_decoder
  import mdd_pkg::*;
#(
  parameter mdd_size_t FLASH_SIZE = MDD_SZ_8K,
  parameter int        RAM_BYTES  = 256
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire mdd_req_t   req,
  input  wire logic [7:0] code_rdata,
  input  wire logic [7:0] sfr_rdata,
  output mdd_rsp_t        rsp,
  output logic [7:0]      sp_value,
  output logic [1:0]      active_bank
);
  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  logic [7:0] ram_q [RAM_BYTES];
  mdd_state_t s_q;
  mdd_state_t s_d;

  logic [7:0] ptr;
  logic [7:0] bit_byte;
  logic [7:0] ram_wa;
  logic [7:0] ram_wd;
  logic       ram_we;
  logic [7:0] ptr_idx;
  logic [7:0] push_at;

  function automatic logic [15:0] flash_top(input mdd_size_t sz);
    case (sz)
      MDD_SZ_4K: flash_top = `MDD_FLASH_4K_TOP;
      MDD_SZ_2K: flash_top = `MDD_FLASH_2K_TOP;
      default:   flash_top = `MDD_FLASH_8K_TOP;
    endcase
  endfunction : flash_top

  // sfr bit map: only column 0/8 registers carry bits
  function automatic logic [7:0] bit_target(input logic [7:0] ba);
    if (ba[7]) begin
      bit_target = {ba[7:3], 3'b000};
    end else begin
      bit_target = `MDD_BITAREA_BASE + {4'h0, ba[6:3]};
    end
  endfunction : bit_target

  // the three sfrs held here; all others come from sfr_rdata
  function automatic logic local_sfr(input logic [7:0] a);
    local_sfr = (a == `MDD_SFR_SP) || (a == `MDD_SFR_PSW) ||
                (a == `MDD_SFR_PROGRAM_STORE_CONTROL);
  endfunction : local_sfr

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.rsp  = '0;
    ram_we   = 1'b0;
    ram_wa   = 8'h00;
    ram_wd   = 8'h00;
    // pointer from r0/r1 of the active bank
    ptr_idx  = {3'b000, s_q.processor_status_word[`MDD_PSW_RS1_BIT],
                s_q.processor_status_word[`MDD_PSW_RS0_BIT], 2'b00,
                req.ptr_sel};
    ptr      = ram_q[ptr_idx];
    bit_byte = bit_target(req.addr[7:0]);
    push_at  = s_q.sp + 8'h01;
    case (req.op)
      MDD_OP_CODE: begin
        // separate space chosen by instruction kind only
        s_d.rsp.code_addr = req.addr;
        s_d.rsp.code_hit  = req.addr <= flash_top(FLASH_SIZE);
        s_d.rsp.code_rsv  = (FLASH_SIZE == MDD_SZ_8K) &&
                            (req.addr > `MDD_FLASH_8K_RSV);
        s_d.rsp.code_we   = req.wr &&
                            s_q.program_store_control[`MDD_PROGRAM_STORE_CONTROL_WE_BIT];
        s_d.rsp.err       = req.wr && !s_q.program_store_control[`MDD_PROGRAM_STORE_CONTROL_WE_BIT];
        s_d.rsp.rdata     = code_rdata;
      end
      MDD_OP_DIRECT: begin
        s_d.rsp.eff_addr = req.addr[7:0];
        if (req.addr[7:0] <= `MDD_DIRECT_TOP) begin
          s_d.rsp.ram_hit = 1'b1;
          s_d.rsp.rdata   = ram_q[req.addr[7:0]];
          ram_we = req.wr;
          ram_wa = req.addr[7:0];
          ram_wd = req.wdata;
        end else begin
          s_d.rsp.sfr_hit = 1'b1;
          if (req.addr[7:0] == `MDD_SFR_SP) begin
            s_d.rsp.rdata = s_q.sp;
            if (req.wr) s_d.sp = req.wdata;
          end else if (req.addr[7:0] == `MDD_SFR_PSW) begin
            s_d.rsp.rdata = s_q.processor_status_word;
            if (req.wr) s_d.processor_status_word = req.wdata;
          end else if (req.addr[7:0] == `MDD_SFR_PROGRAM_STORE_CONTROL) begin
            s_d.rsp.rdata = s_q.program_store_control;
            if (req.wr) s_d.program_store_control = req.wdata;
          end else begin
            // unoccupied addresses pass through unchecked
            s_d.rsp.rdata = sfr_rdata;
          end
        end
      end
      MDD_OP_INDIR: begin
        // indirect reaches all 256 bytes of ram
        s_d.rsp.eff_addr = ptr;
        s_d.rsp.ram_hit  = 1'b1;
        s_d.rsp.rdata    = ram_q[ptr];
        ram_we = req.wr;
        ram_wa = ptr;
        ram_wd = req.wdata;
      end
      MDD_OP_BIT: begin
        // ram bit or sfr bit is chosen by address bit 7, not by the op
        s_d.rsp.eff_addr = bit_byte;
        if (!req.addr[7]) begin
          s_d.rsp.ram_hit = 1'b1;
          s_d.rsp.rbit    = ram_q[bit_byte][req.addr[2:0]];
          ram_we = req.wr;
          ram_wa = bit_byte;
          ram_wd = ram_q[bit_byte];
          ram_wd[req.addr[2:0]] = req.wdata[0];
        end else begin
          s_d.rsp.sfr_hit = 1'b1;
          if (bit_byte == `MDD_SFR_PSW) begin
            s_d.rsp.rbit = s_q.processor_status_word[req.addr[2:0]];
            if (req.wr) s_d.processor_status_word[req.addr[2:0]] = req.wdata[0];
          end else begin
            s_d.rsp.rbit = sfr_rdata[req.addr[2:0]];
          end
        end
      end
      MDD_OP_PUSH: begin
        // write sp+1 then bump sp; wraps through 256 bytes
        s_d.rsp.eff_addr = push_at;
        s_d.rsp.ram_hit  = 1'b1;
        ram_we = 1'b1;
        ram_wa = push_at;
        ram_wd = req.wdata;
        s_d.sp = push_at;
      end
      MDD_OP_POP: begin
        s_d.rsp.eff_addr = s_q.sp;
        s_d.rsp.ram_hit  = 1'b1;
        s_d.rsp.rdata    = ram_q[s_q.sp];
        s_d.sp = s_q.sp - 8'h01;
      end
      default: begin
        s_d.rsp = '0;
      end
    endcase
    // direct-space register reads above bypass local_sfr only by name
    if (req.op == MDD_OP_DIRECT && req.addr[7] &&
        !local_sfr(req.addr[7:0])) begin
      s_d.rsp.sfr_hit = 1'b1;
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_q       <= '0;
      s_q.sp    <= `MDD_SP_RESET;
      s_q.processor_status_word   <= `MDD_PSW_RESET;
      s_q.program_store_control <= `MDD_PROGRAM_STORE_CONTROL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ram holds no reset: contents are undefined after power-up
  always_ff @(posedge sys_clk) begin
    if (ram_we) begin
      ram_q[ram_wa] <= ram_wd;
    end
  end

  assign rsp         = s_q.rsp;
  assign sp_value    = s_q.sp;
  assign active_bank = {s_q.processor_status_word[`MDD_PSW_RS1_BIT], s_q.processor_status_word[`MDD_PSW_RS0_BIT]};

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  chk_sp_reset: assert property (@(posedge sys_clk)
    !resetn |=> s_q.sp == 8'h07)
    else $error("stack pointer not 0x07 after reset");
  chk_push_addr: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    req.op == MDD_OP_PUSH |=> rsp.eff_addr == $past(s_q.sp) + 8'h01
      && s_q.sp == rsp.eff_addr)
    else $error("push address or pointer wrong");
  chk_direct_sfr: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    req.op == MDD_OP_DIRECT && req.addr[7] |=> rsp.sfr_hit && !rsp.ram_hit)
    else $error("direct upper access missed sfr space");
  chk_indir_ram: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    req.op == MDD_OP_INDIR |=> rsp.ram_hit && !rsp.sfr_hit)
    else $error("indirect access missed ram");
  chk_low_direct: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    req.op == MDD_OP_DIRECT && !req.addr[7] |=> rsp.ram_hit)
    else $error("lower direct access missed ram");
  chk_code_we: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    rsp.code_we |-> $past(s_q.program_store_control[0]) && $past(req.wr))
    else $error("program write without enable");
  chk_bit_sfr: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    req.op == MDD_OP_BIT && req.addr[7] |=> rsp.eff_addr[2:0] == 3'b000)
    else $error("sfr bit target not column 0/8");
  chk_bit_ram: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    req.op == MDD_OP_BIT && !req.addr[7] |=>
      rsp.eff_addr == 8'h20 + {4'h0, $past(req.addr[6:3])})
    else $error("bit area byte wrong");
  chk_code_top: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    req.op == MDD_OP_CODE |=> rsp.code_hit == (rsp.code_addr <=
      flash_top(FLASH_SIZE)))
    else $error("flash range decode wrong");
endmodule : mdd_decoder
`default_nettype wire

// file: mdd_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module mdd_far_model
  import mdd_pkg::*;
(
  input  wire mdd_req_t   req,
  output logic [7:0]      code_rdata,
  output logic [7:0]      sfr_rdata
);
  // ----------------------------
  // flash and peripheral sfrs
  // ----------------------------
  // data follows the address, so a wrong source mux shows as a bad byte
  assign code_rdata = req.addr[15:8] ^ req.addr[7:0] ^ 8'h5a;
  // a bit access names the byte at its column 0/8 address, not the bit
  assign sfr_rdata  = ((req.op == MDD_OP_BIT) ?
                       {req.addr[7:3], 3'b000} : req.addr[7:0]) ^ 8'ha5;
endmodule : mdd_far_model
`default_nettype wire

// file: mdd_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mdd_decoder_bench
  import mdd_pkg::*;
;
  logic        sys_clk;
  logic        resetn;
  mdd_req_t    req;
  logic [7:0]  code_rdata;
  logic [7:0]  sfr_rdata;
  mdd_rsp_t    rsp_v [3];
  logic [7:0]  sp_v [3];
  logic [1:0]  bank_v [3];
  mdd_rsp_t    r;
  int          miscompares;
  int          tests_run;
  logic [15:0] tbl [4] = '{16'h07ff, 16'h0800, 16'h0fff, 16'h1000};

  // ----------------------------
  // one decoder per flash size
  // ----------------------------
  for (genvar g = 0; g < 3; g++) begin : g_size
    mdd_decoder #(.FLASH_SIZE(mdd_size_t'(2'(g)))) u_mdd_decoder (
      .sys_clk     (sys_clk),
      .resetn      (resetn),
      .req         (req),
      .code_rdata  (code_rdata),
      .sfr_rdata   (sfr_rdata),
      .rsp         (rsp_v[g]),
      .sp_value    (sp_v[g]),
      .active_bank (bank_v[g])
    );
  end
  mdd_far_model u_mdd_far_model (
    .req        (req),
    .code_rdata (code_rdata),
    .sfr_rdata  (sfr_rdata)
  );

  always #5 sys_clk = ~sys_clk;

  // ----------------------------
  // access and compare tasks
  // ----------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // answer stands one cycle only, so it is captured at that edge
  task automatic acc(input mdd_op_t op, input logic wr,
                     input logic [15:0] a, input logic [7:0] d,
                     input logic p);
    @(posedge sys_clk);
    #1;
    req = '{op: op, wr: wr, addr: a, wdata: d, ptr_sel: p, bitpos: a[2:0]};
    @(posedge sys_clk);
    #1;
    req.op = MDD_OP_NONE;
    r = rsp_v[0];
  endtask : acc

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // 27 accesses of two cycles each; this is far beyond that
  initial begin
    #50000;
    miscompares++;
    complete_run();
  end

  // ----------------------------
  // tests
  // ----------------------------
  // sfr reads also touch unoccupied addresses 0x90 and 0x88
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    req = '0;
    miscompares = 0;
    tests_run = 0;
    repeat (16) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    chk(sp_v[0], 16'h0007);
    chk(bank_v[0], 16'h0000);
    acc(MDD_OP_PUSH, 1'b1, 16'h0000, 8'h55, 1'b0);
    chk(r.eff_addr, 16'h0008);
    chk(r.ram_hit, 16'h0001);
    chk(sp_v[0], 16'h0008);
    acc(MDD_OP_DIRECT, 1'b1, 16'h0081, 8'hff, 1'b0);
    chk(r.sfr_hit, 16'h0001);
    chk(sp_v[0], 16'h00ff);
    acc(MDD_OP_PUSH, 1'b1, 16'h0000, 8'h66, 1'b0);
    chk(r.eff_addr, 16'h0000);
    acc(MDD_OP_POP, 1'b0, 16'h0000, 8'h00, 1'b0);
    chk(r.rdata, 16'h0066);
    chk(sp_v[0], 16'h00ff);
    $display("test stack done");
    acc(MDD_OP_DIRECT, 1'b1, 16'h0000, 8'h90, 1'b0);
    acc(MDD_OP_INDIR, 1'b1, 16'h0000, 8'h3c, 1'b0);
    chk(r.eff_addr, 16'h0090);
    acc(MDD_OP_DIRECT, 1'b0, 16'h0090, 8'h00, 1'b0);
    chk(r.sfr_hit, 16'h0001);
    chk(r.rdata, 16'h0035);
    chk(r.eff_addr, 16'h0090);
    acc(MDD_OP_INDIR, 1'b0, 16'h0000, 8'h00, 1'b0);
    chk(r.rdata, 16'h003c);
    chk(r.ram_hit, 16'h0001);
    $display("test upper ram done");
    acc(MDD_OP_DIRECT, 1'b1, 16'h00d0, 8'h18, 1'b0);
    chk(bank_v[0], 16'h0003);
    acc(MDD_OP_DIRECT, 1'b1, 16'h0019, 8'h40, 1'b0);
    acc(MDD_OP_INDIR, 1'b1, 16'h0000, 8'h77, 1'b1);
    chk(r.eff_addr, 16'h0040);
    acc(MDD_OP_DIRECT, 1'b0, 16'h0040, 8'h00, 1'b0);
    chk(r.rdata, 16'h0077);
    $display("test banks done");
    acc(MDD_OP_DIRECT, 1'b1, 16'h0022, 8'h08, 1'b0);
    acc(MDD_OP_BIT, 1'b0, 16'h0013, 8'h00, 1'b0);
    chk(r.rbit, 16'h0001);
    chk(r.eff_addr, 16'h0022);
    acc(MDD_OP_BIT, 1'b1, 16'h0010, 8'h01, 1'b0);
    acc(MDD_OP_DIRECT, 1'b0, 16'h0022, 8'h00, 1'b0);
    chk(r.rdata, 16'h0009);
    acc(MDD_OP_BIT, 1'b1, 16'h00d3, 8'h00, 1'b0);
    chk(r.sfr_hit, 16'h0001);
    chk(bank_v[0], 16'h0002);
    acc(MDD_OP_BIT, 1'b0, 16'h008a, 8'h00, 1'b0);
    chk(r.eff_addr, 16'h0088);
    chk(r.rbit, 16'h0001);
    $display("test bits done");
    acc(MDD_OP_CODE, 1'b0, 16'h1e00, 8'h00, 1'b0);
    chk(r.code_hit, 16'h0001);
    chk(r.code_rsv, 16'h0001);
    chk(r.rdata, 16'h0044);
    chk(r.code_addr, 16'h1e00);
    acc(MDD_OP_CODE, 1'b0, 16'h2000, 8'h00, 1'b0);
    chk(r.code_hit, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      acc(MDD_OP_CODE, 1'b0, tbl[i], 8'h00, 1'b0);
      chk(rsp_v[1].code_hit, 16'(tbl[i] <= 16'h0fff));
      chk(rsp_v[2].code_hit, 16'(tbl[i] <= 16'h07ff));
    end
    acc(MDD_OP_CODE, 1'b1, 16'h0100, 8'hab, 1'b0);
    chk(r.err, 16'h0001);
    chk(r.code_we, 16'h0000);
    acc(MDD_OP_DIRECT, 1'b1, 16'h008f, 8'h01, 1'b0);
    acc(MDD_OP_CODE, 1'b1, 16'h0100, 8'hab, 1'b0);
    chk(r.code_we, 16'h0001);
    chk(r.err, 16'h0000);
    $display("test program done");
    complete_run();
  end
endmodule : mdd_decoder_bench
`default_nettype wire
